// ===== inc/rmce_pkg.sv
// Package for the reader mode and card enrollment block.
// Assumes a 10 MHz reference clock and a plain register port.
package rmce_pkg;
  // Clock rate in hertz and the programming session timeout in seconds.
  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned PROG_TIMEOUT_S  = 15;
  localparam int unsigned PROG_TIMEOUT_CY = CLK_HZ * PROG_TIMEOUT_S;
  // Indicator flash half periods in milliseconds and their cycle counts.
  localparam int unsigned SLOW_FLASH_MS   = 500;
  localparam int unsigned FAST_FLASH_MS   = 100;
  localparam int unsigned SLOW_FLASH_CY   = CLK_HZ / 1000 * SLOW_FLASH_MS;
  localparam int unsigned FAST_FLASH_CY   = CLK_HZ / 1000 * FAST_FLASH_MS;
  // Power-up beep length, gap and green blink length in milliseconds.
  localparam int unsigned BEEP_MS         = 400;
  localparam int unsigned BEEP_CY         = CLK_HZ / 1000 * BEEP_MS;
  localparam int unsigned BLINK_MS        = 100;
  localparam int unsigned BLINK_CY        = CLK_HZ / 1000 * BLINK_MS;
  // Consecutive programming card reads that switch the sub-mode.
  localparam logic [2:0]  REPEAT_COUNT    = 3'h5;
  // Card memory geometry.
  localparam int unsigned CODE_W          = 45;
  localparam int unsigned MEM_DEPTH       = 16;
  localparam int unsigned IDX_W           = 4;
  // Reason codes for own reads and entry reader reads.
  localparam logic [7:0]  REASON_OWN      = 8'h00;
  localparam logic [7:0]  REASON_ENTRY    = 8'hff;
  // Register offsets.
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h4;
  localparam logic [3:0]  REG_COUNT       = 4'h8;
  // Control field positions.
  localparam int unsigned CTRL_ONLINE     = 0;
  localparam int unsigned CTRL_LEN_LO     = 1;
  localparam int unsigned CTRL_PORT_LO    = 3;
  localparam int unsigned CTRL_FMT_LO     = 5;
  localparam int unsigned CTRL_HIDF_LO    = 7;
  localparam int unsigned CTRL_ADDRSET    = 9;
  localparam logic [9:0]  CTRL_RESET      = 10'h000;
  // Code length selection for the first technology.
  localparam logic [1:0]  LEN_40          = 2'h0;
  localparam logic [1:0]  LEN_32          = 2'h1;
  localparam logic [1:0]  LEN_24          = 2'h2;
  // Port role selection.
  localparam logic [1:0]  PORT_STD        = 2'h0;
  localparam logic [1:0]  PORT_WOUT       = 2'h1;
  localparam logic [1:0]  PORT_WIN        = 2'h2;
  // Output frame sizes.
  localparam logic [1:0]  FMT_26          = 2'h0;
  localparam logic [1:0]  FMT_32          = 2'h1;
  localparam logic [1:0]  FMT_42          = 2'h2;
  localparam logic [1:0]  FMT_44          = 2'h3;
  localparam logic [5:0]  BITS_26         = 6'h1a;
  localparam logic [5:0]  BITS_32         = 6'h20;
  localparam logic [5:0]  BITS_42         = 6'h2a;
  localparam logic [5:0]  BITS_44         = 6'h2c;
  localparam logic [5:0]  BITS_45         = 6'h2d;
  // Second technology format selection.
  localparam logic [1:0]  HID_AUTO        = 2'h0;
  localparam logic [1:0]  HID_RAW         = 2'h1;
  localparam logic [1:0]  HID_USER        = 2'h2;
  // Programming state machine.
  typedef enum logic [2:0] {
    RMCE_IDLE, RMCE_ENROLL, RMCE_REVOKE, RMCE_NBR_WAIT, RMCE_NBR_REF
  } rmce_state_t;
endpackage

// ===== logic/rmce_top.sv
// Reader mode selection, code formatting and programming card enrollment.
// Assumes card reads arrive as one-cycle pulses from same-clock reader logic.
`timescale 1ns/1ps
// How it works
// - Same behaviour online or offline; archive flag
// - Programming card read enters programming mode
// - First technology cut to 24/32/40 bits
// - Second technology 26/32 recognized, else 45
// - Standard mode: expander control, pin is tamper
// - Wiegand out: cut, then 26/32/42/44 frame
// - Second technology sent in standard format
// - Wiegand out: pin is tamper input
// - Power-up two beeps, red on, green blinks
// - Wiegand out: low inputs drive beeper and yellow
// - Relay follows tamper alarm in Wiegand out
// - Entry reads reason 255, own reads zero
// - Entry reader mode: pin drives buzzer
// - Wiegand in and out never together
// - Address setting mode ignores programming cards
// - Enrolled cards carry no schedule restriction
// - Enroll session adds cards, exits after timeout
// - Revoke session deletes cards, exits after timeout
// - Slow yellow; five enrolls give fast neighbour-delete
// - Reference card then revoke/enroll deletes neighbour
// - Five more revokes erase all cards
// - New card stored after last enrolled
module rmce_top
  import rmce_pkg::*;
#(
  parameter int unsigned TIMEOUT_CY = PROG_TIMEOUT_CY, // Session timeout in cycles.
  parameter int unsigned SLOW_CY    = SLOW_FLASH_CY,   // Slow flash half period.
  parameter int unsigned FAST_CY    = FAST_FLASH_CY,   // Fast flash half period.
  parameter int unsigned BEEP_LEN   = BEEP_CY,         // Power-up beep and gap length.
  parameter int unsigned BLINK_LEN  = BLINK_CY         // Green blink length.
)
(
  input  wire logic              ref_clk,        // System clock.
  input  wire logic              rst,            // Synchronous reset, active high.
  input  wire logic [3:0]        reg_addr,       // Register byte address.
  input  wire logic [31:0]       reg_wdata,      // Register write data.
  input  wire logic              reg_wr,         // Write strobe.
  input  wire logic              reg_rd,         // Read strobe.
  output logic      [31:0]       reg_rdata,      // Read data, one cycle after the strobe.
  input  wire logic              card_valid,     // Own reader delivered a card, one pulse.
  input  wire logic              card_tech2,     // Card is second technology.
  input  wire logic [CODE_W-1:0] card_code,      // Raw card code.
  input  wire logic [5:0]        card_bits,      // Recognized length of a second-technology code.
  input  wire logic              card_enroll,    // Card is the enroll programming card.
  input  wire logic              card_revoke,    // Card is the revoke programming card.
  input  wire logic              entry_valid,    // Entry reader delivered a code, one pulse.
  input  wire logic [CODE_W-1:0] entry_code,     // Code from the entry reader.
  input  wire logic              io_pin_i,       // Shared pin level.
  input  wire logic              tamper_local,   // Own tamper sensor alarm.
  input  wire logic              in1_pin,        // Input 1, low sounds the beeper in Wiegand out.
  input  wire logic              in2_pin,        // Input 2, low lights the yellow indicator in Wiegand out.
  output logic                   io_pin_o,       // Shared pin drive level.
  output logic                   io_pin_oe_n,    // Shared pin enable, low while driving.
  output logic                   exp_ctrl_en,    // Port drives the external expander.
  output logic                   wout_en,        // Port transmits Wiegand frames.
  output logic                   win_en,         // Port receives Wiegand frames.
  output logic                   tx_valid,       // Formatted frame ready, one pulse.
  output logic      [CODE_W-1:0] tx_code,        // Formatted code.
  output logic      [5:0]        tx_bits,        // Frame length in bits.
  output logic      [7:0]        tx_reason,      // Reason code of the identification.
  output logic                   relay_out,      // Relay output.
  output logic                   beeper,         // Beeper drive.
  output logic                   led_red,        // Red indicator.
  output logic                   led_green,      // Green indicator.
  output logic                   led_yellow,     // Yellow indicator.
  output logic                   archive_req,    // Archive readout requested on going online.
  output logic                   prog_active     // Programming mode active.
);

  // Control register and derived fields.
  logic [9:0]  ctrl_q;                          // Software control word.
  wire         online   = ctrl_q[CTRL_ONLINE];   // Online mode flag.
  wire  [1:0]  len_sel  = ctrl_q[CTRL_LEN_LO +: 2]; // First technology length.
  wire  [1:0]  port_sel = ctrl_q[CTRL_PORT_LO +: 2]; // Port role.
  wire  [1:0]  fmt_sel  = ctrl_q[CTRL_FMT_LO +: 2]; // Output frame size.
  wire  [1:0]  hid_sel  = ctrl_q[CTRL_HIDF_LO +: 2]; // Second technology format.
  wire         addr_set = ctrl_q[CTRL_ADDRSET];  // Hardware address setting mode.
  // Role decode; the input role wins only when output is not chosen.
  wire         role_wout = (port_sel == PORT_WOUT);
  wire         role_win  = (port_sel == PORT_WIN);
  wire         role_std  = !role_wout && !role_win;

  // Input synchronisers: three stages, a change counts once stages two and three agree.
  logic [2:0]  io_s_q, in1_s_q, in2_s_q;        // Synchroniser chains.
  logic        io_f_q, in1_f_q, in2_f_q;        // Filtered levels.
  logic [2:0]  tam_s_q;                         // Own tamper sensor chain.
  logic        tam_f_q;                         // Filtered own tamper level.

  // Card memory and pointers.
  logic [CODE_W-1:0] mem_q [MEM_DEPTH];         // Stored card codes.
  logic [MEM_DEPTH-1:0] used_q;                 // Slot holds a card.
  logic [IDX_W-1:0]  wr_ptr_q;                  // Slot after the last enrolled card.
  logic [IDX_W-1:0]  ref_q;                     // Reference slot for neighbour delete.
  logic [4:0]        count_q;                   // Stored card count.

  // Programming state and timers.
  rmce_state_t state_q;                         // Programming state.
  logic [2:0]  rep_q;                           // Consecutive programming card reads.
  logic [31:0] tmo_q;                           // Inactivity timer.
  logic [31:0] flash_q;                         // Flash divider.
  logic        flash_q_lvl;                     // Flash level.
  logic [31:0] pu_q;                            // Power-up sequence timer.
  logic [2:0]  pu_ph_q;                         // Power-up phase.
  logic [31:0] blink_q;                         // Green blink timer.
  logic        online_q;                        // Online flag delayed.

  // Returns the index of a stored matching code, with hit flag in the top bit.
  function automatic logic [IDX_W:0] find(input logic [CODE_W-1:0] c,
                                          input logic [MEM_DEPTH-1:0] u);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = 0; i < MEM_DEPTH; i++)
    begin
      if (u[i] && mem_q[i] == c)
      begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // Keeps the low n bits of a code.
  function automatic logic [CODE_W-1:0] keep(input logic [CODE_W-1:0] c, input logic [5:0] n);
    logic [CODE_W-1:0] m;
    m = ~({CODE_W{1'b1}} << n);
    return c & m;
  endfunction

  // Code formatting for both technologies.
  wire  [5:0]  len1 = (len_sel == LEN_24) ? 6'h18 : (len_sel == LEN_32) ? BITS_32 : 6'h28;
  wire  [5:0]  frame1 = (fmt_sel == FMT_26) ? BITS_26 : (fmt_sel == FMT_32) ? BITS_32 :
                        (fmt_sel == FMT_42) ? BITS_42 : BITS_44;
  wire         hid_rec = (card_bits == BITS_26) || (card_bits == BITS_32);
  wire  [5:0]  len2 = (hid_sel == HID_RAW) ? BITS_45 :
                      (hid_sel == HID_USER) ? card_bits :
                      (hid_rec ? card_bits : BITS_45);
  wire  [CODE_W-1:0] code_fmt = card_tech2 ? keep(card_code, len2) : keep(card_code, len1);
  wire  [5:0]  bits_fmt = card_tech2 ? len2 : (role_wout ? frame1 : len1);

  // Programming card and lookup decode.
  wire         prog_card = card_valid && (card_enroll || card_revoke);
  wire         prog_ok   = prog_card && !addr_set;
  wire         user_card = card_valid && !card_enroll && !card_revoke;
  wire  [IDX_W:0] hit    = find(code_fmt, used_q);
  wire         tmo_done  = (tmo_q == 32'h0);
  wire  [IDX_W-1:0] next_i = ref_q + 1'b1;
  wire  [IDX_W-1:0] ref_prev = ref_q - 1'b1;

  // Register writes and port synchronisers.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_q  <= CTRL_RESET;
      io_s_q  <= 3'h0;
      in1_s_q <= 3'h7;
      in2_s_q <= 3'h7;
      io_f_q  <= 1'b0;
      tam_s_q <= 3'h0;
      tam_f_q <= 1'b0;
      in1_f_q <= 1'b1;
      in2_f_q <= 1'b1;
    end
    else
    begin
      if (reg_wr && reg_addr == REG_CTRL)
      begin
        ctrl_q <= reg_wdata[9:0];
      end
      io_s_q  <= {io_s_q[1:0], io_pin_i};
      tam_s_q <= {tam_s_q[1:0], tamper_local};
      // The sensor is asynchronous, so it is filtered like the pins.
      if (tam_s_q[2] == tam_s_q[1])
      begin
        tam_f_q <= tam_s_q[2];
      end
      in1_s_q <= {in1_s_q[1:0], in1_pin};
      in2_s_q <= {in2_s_q[1:0], in2_pin};
      if (io_s_q[2] == io_s_q[1])
      begin
        io_f_q <= io_s_q[2];
      end
      if (in1_s_q[2] == in1_s_q[1])
      begin
        in1_f_q <= in1_s_q[2];
      end
      if (in2_s_q[2] == in2_s_q[1])
      begin
        in2_f_q <= in2_s_q[2];
      end
    end
  end

  // Register reads: status shows mode and state, count shows stored cards.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h0;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL:   reg_rdata <= {22'h0, ctrl_q};
        REG_STATUS: reg_rdata <= {24'h0, io_f_q, tam_f_q, prog_active, 2'h0, state_q};
        REG_COUNT:  reg_rdata <= {27'h0, count_q};
        default:    reg_rdata <= 32'h0;
      endcase
    end
  end

  // Programming state machine and card memory.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q  <= RMCE_IDLE;
      rep_q    <= 3'h0;
      tmo_q    <= 32'h0;
      used_q   <= '0;
      wr_ptr_q <= '0;
      ref_q    <= '0;
      count_q  <= 5'h0;
      for (int i = 0; i < MEM_DEPTH; i++)
      begin
        mem_q[i] <= '0;
      end
    end
    else
    begin
      if (!tmo_done)
      begin
        tmo_q <= tmo_q - 32'h1;
      end
      case (state_q)
        RMCE_IDLE:
        begin
          // Entry works alike online and offline.
          if (prog_ok)
          begin
            state_q <= card_enroll ? RMCE_ENROLL : RMCE_REVOKE;
            rep_q   <= 3'h0;
            tmo_q   <= TIMEOUT_CY;
          end
        end
        RMCE_ENROLL:
        begin
          if (tmo_done)
          begin
            state_q <= RMCE_IDLE;
          end
          else if (card_valid && card_enroll)
          begin
            tmo_q <= TIMEOUT_CY;
            rep_q <= rep_q + 3'h1;
            if (rep_q + 3'h1 == REPEAT_COUNT)
            begin
              state_q <= RMCE_NBR_WAIT;
            end
          end
          else if (user_card)
          begin
            tmo_q <= TIMEOUT_CY;
            rep_q <= 3'h0;
            // Stored with no schedule: presence alone grants access.
            if (!hit[IDX_W] && !used_q[wr_ptr_q])
            begin
              mem_q[wr_ptr_q]  <= code_fmt;
              used_q[wr_ptr_q] <= 1'b1;
              wr_ptr_q         <= wr_ptr_q + 1'b1;
              count_q          <= count_q + 5'h1;
            end
          end
          else if (card_valid)
          begin
            rep_q <= 3'h0;
          end
        end
        RMCE_REVOKE:
        begin
          if (tmo_done)
          begin
            state_q <= RMCE_IDLE;
          end
          else if (card_valid && card_revoke)
          begin
            tmo_q <= TIMEOUT_CY;
            rep_q <= rep_q + 3'h1;
            if (rep_q + 3'h1 == REPEAT_COUNT)
            begin
              used_q   <= '0;
              wr_ptr_q <= '0;
              count_q  <= 5'h0;
              state_q  <= RMCE_IDLE;
            end
          end
          else if (user_card)
          begin
            tmo_q <= TIMEOUT_CY;
            rep_q <= 3'h0;
            if (hit[IDX_W])
            begin
              used_q[hit[IDX_W-1:0]] <= 1'b0;
              count_q <= count_q - 5'h1;
            end
          end
          else if (card_valid)
          begin
            rep_q <= 3'h0;
          end
        end
        RMCE_NBR_WAIT:
        begin
          if (tmo_done)
          begin
            state_q <= RMCE_IDLE;
          end
          else if (user_card && hit[IDX_W])
          begin
            ref_q   <= hit[IDX_W-1:0];
            tmo_q   <= TIMEOUT_CY;
            state_q <= RMCE_NBR_REF;
          end
        end
        RMCE_NBR_REF:
        begin
          if (tmo_done)
          begin
            state_q <= RMCE_IDLE;
          end
          else if (card_valid && (card_revoke || card_enroll))
          begin
            // Revoke removes the slot before the reference, enroll the slot after.
            if (card_revoke && used_q[ref_prev])
            begin
              used_q[ref_prev] <= 1'b0;
              count_q <= count_q - 5'h1;
            end
            else if (card_enroll && used_q[next_i])
            begin
              used_q[next_i] <= 1'b0;
              count_q <= count_q - 5'h1;
            end
            state_q <= RMCE_IDLE;
          end
        end
        default:
        begin
          state_q <= RMCE_IDLE;
        end
      endcase
    end
  end

  // Flash divider for the yellow indicator; fast in neighbour-delete states.
  wire  [31:0] flash_len = (state_q == RMCE_NBR_WAIT || state_q == RMCE_NBR_REF) ? FAST_CY : SLOW_CY;
  always_ff @(posedge ref_clk)
  begin
    if (rst || state_q == RMCE_IDLE)
    begin
      flash_q     <= 32'h0;
      flash_q_lvl <= 1'b0;
    end
    else if (flash_q >= flash_len - 32'h1)
    begin
      flash_q     <= 32'h0;
      flash_q_lvl <= !flash_q_lvl;
    end
    else
    begin
      flash_q <= flash_q + 32'h1;
    end
  end

  // Power-up beeps and green blink per card read.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pu_q    <= 32'h0;
      pu_ph_q <= 3'h0;
      blink_q <= 32'h0;
    end
    else
    begin
      if (pu_ph_q != 3'h4)
      begin
        if (pu_q >= BEEP_LEN - 32'h1)
        begin
          pu_q    <= 32'h0;
          pu_ph_q <= pu_ph_q + 3'h1;
        end
        else
        begin
          pu_q <= pu_q + 32'h1;
        end
      end
      if (card_valid || entry_valid)
      begin
        blink_q <= BLINK_LEN;
      end
      else if (blink_q != 32'h0)
      begin
        blink_q <= blink_q - 32'h1;
      end
    end
  end

  // Outputs, formatted frames and port roles.
  wire         pu_beep = (pu_ph_q == 3'h0) || (pu_ph_q == 3'h2);
  wire         tamper_any = tam_f_q || (!role_win && io_f_q);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      io_pin_o    <= 1'b0;
      io_pin_oe_n <= 1'b1;
      exp_ctrl_en <= 1'b0;
      wout_en     <= 1'b0;
      win_en      <= 1'b0;
      tx_valid    <= 1'b0;
      tx_code     <= '0;
      tx_bits     <= 6'h0;
      tx_reason   <= REASON_OWN;
      relay_out   <= 1'b0;
      beeper      <= 1'b0;
      led_red     <= 1'b0;
      led_green   <= 1'b0;
      led_yellow  <= 1'b0;
      archive_req <= 1'b0;
      prog_active <= 1'b0;
      online_q    <= 1'b0;
    end
    else
    begin
      exp_ctrl_en <= role_std;
      wout_en     <= role_wout;
      win_en      <= role_win;
      io_pin_oe_n <= !role_win;
      io_pin_o    <= role_win && !in1_f_q;
      relay_out   <= role_wout && tamper_any;
      beeper      <= pu_beep || (role_wout && !in1_f_q);
      led_red     <= 1'b1;
      led_green   <= (blink_q != 32'h0);
      led_yellow  <= (state_q != RMCE_IDLE) ? flash_q_lvl : (role_wout && !in2_f_q);
      prog_active <= (state_q != RMCE_IDLE);
      online_q    <= online;
      archive_req <= online && !online_q;
      tx_valid    <= 1'b0;
      if (user_card && state_q == RMCE_IDLE)
      begin
        tx_valid  <= 1'b1;
        tx_code   <= code_fmt;
        tx_bits   <= bits_fmt;
        tx_reason <= REASON_OWN;
      end
      else if (entry_valid && role_win)
      begin
        tx_valid  <= 1'b1;
        tx_code   <= entry_code;
        tx_bits   <= BITS_45;
        tx_reason <= REASON_ENTRY;
      end
    end
  end

endmodule

// ===== tb/rmce_ctrl_model.sv
// Model of the Wiegand controller that drives the two control inputs.
// Assumes the bench requests beeper and yellow lamp as levels.
`timescale 1ns/1ps
module rmce_ctrl_model (
  input  wire logic ref_clk,  // Shared clock.
  input  wire logic beep_req, // Bench wants the beeper.
  input  wire logic lamp_req, // Bench wants the yellow lamp.
  output logic      in1_pin,  // Input 1, low is active.
  output logic      in2_pin   // Input 2, low is active.
);
  // Both lines idle high until the first request.
  initial
  begin
    in1_pin = 1'h1;
    in2_pin = 1'h1;
  end
  // Lines change just after the edge, as the real controller does.
  always @(posedge ref_clk)
  begin
    in1_pin <= !beep_req;
    in2_pin <= !lamp_req;
  end
endmodule

// ===== tb/rmce_assertions.sv
// Checker on the ports of the reader mode block.
// Bound to every rmce_top; sees only its ports.
`timescale 1ns/1ps
module rmce_chk
  import rmce_pkg::*;
(
  input wire logic       ref_clk, rst, card_valid, card_enroll, card_revoke,
  input wire logic       in1_pin, in2_pin, tamper_local, io_pin_oe_n, exp_ctrl_en,
  input wire logic       wout_en, win_en, tx_valid, relay_out, beeper, led_red,
  input wire logic       led_yellow, archive_req, prog_active,
  input wire logic [5:0] tx_bits,
  input wire logic [7:0] tx_reason
);
  // Programming card read one cycle late, to trace prog_active back to it.
  logic pc_q;
  always_ff @(posedge ref_clk) pc_q <= card_valid && (card_enroll || card_revoke);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Inputs held long enough to pass the three-edge filter.
  sequence beep_low; (!in1_pin && wout_en)[*6]; endsequence
  sequence lamp_low; (!in2_pin && wout_en && !prog_active)[*6]; endsequence
  sequence alarm_on; (tamper_local && wout_en)[*6]; endsequence
  modes_apart_a: assert property (!(win_en && wout_en)) else $error("Both roles on.");
  one_role_a: assert property (!$past(rst) |-> $onehot({exp_ctrl_en, wout_en, win_en})) else $error("Role.");
  powerup_a: assert property ($past(rst) |-> ##[0:2] (led_red && beeper)) else $error("Power-up.");
  beep_follow_a: assert property (beep_low |-> beeper) else $error("Beeper.");
  lamp_follow_a: assert property (lamp_low |-> led_yellow) else $error("Yellow.");
  relay_alarm_a: assert property (alarm_on |-> relay_out) else $error("Relay.");
  buzzer_drive_a: assert property (!io_pin_oe_n |-> win_en || $past(win_en)) else $error("Pin drive.");
  reason_code_a: assert property (tx_valid |-> tx_reason == REASON_OWN ||
    (tx_reason == REASON_ENTRY && tx_bits == BITS_45)) else $error("Reason.");
  prog_entry_a: assert property ($rose(prog_active) |-> pc_q || $past(pc_q) || $past(pc_q, 2)) else $error("Prog.");
  archive_pulse_a: assert property (archive_req |=> !archive_req) else $error("Archive.");
endmodule
bind rmce_top rmce_chk u_chk (.*);

// ===== tb/tb_top.sv
// Self-checking bench for the reader mode and enrollment block.
// Assumes the design, its checker and the controller model compile first.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module tb_top
  import rmce_pkg::*;
;
  localparam int TO = 50; // Shortened session timeout.
  logic ref_clk = '0, rst = '1, reg_wr = '0, reg_rd = '0, card_valid = '0, card_tech2 = '0, card_enroll = '0;
  logic card_revoke = '0, entry_valid = '0, io_pin_i = '0, tamper_local = '0, beep_req = '0, lamp_req = '0;
  logic [3:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, v;
  logic [44:0] card_code = '0, entry_code = '0, tx_code, c;
  logic [5:0] card_bits = '0, tx_bits;
  logic [7:0] tx_reason;
  logic in1_pin, in2_pin, io_pin_o, io_pin_oe_n, exp_ctrl_en, wout_en, win_en, tx_valid, relay_out;
  logic beeper, led_red, led_green, led_yellow, archive_req, prog_active;
  logic [5:0] fb [4] = '{BITS_26, BITS_32, BITS_42, BITS_44}; // Frame size by select.
  int fails = 0, checked = 0, arn = 0, txn = 0;
  rmce_top #(.TIMEOUT_CY(TO), .SLOW_CY(4), .FAST_CY(2), .BEEP_LEN(4), .BLINK_LEN(3)) uut (.*);
  rmce_ctrl_model ctl (.ref_clk, .beep_req, .lamp_req, .in1_pin, .in2_pin);
  always #50 ref_clk = ~ref_clk;
  // Counts pulses so that stale frames or requests never pass.
  always @(posedge ref_clk) if (archive_req === 1'h1) arn++;
  always @(posedge ref_clk) if (tx_valid === 1'h1) txn++;
  task wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1; @(posedge ref_clk);
    reg_wr <= 1'h0; @(posedge ref_clk);
  endtask
  // Read data appear in the cycle after the strobe and hold until the next read.
  task rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a; reg_rd <= 1'h1; @(posedge ref_clk);
    reg_rd <= 1'h0; #1 d = reg_rdata; @(posedge ref_clk);
  endtask
  task card(input logic t, e, r, input logic [44:0] x);
    txn = 0;
    card_valid <= 1'h1; card_tech2 <= t; card_enroll <= e; card_revoke <= r; card_code <= x;
    @(posedge ref_clk); card_valid <= 1'h0; repeat (4) @(posedge ref_clk);
  endtask
  task st(input logic [2:0] s, input logic [4:0] n);
    rd(REG_STATUS, v); `CHK("state", s, v[2:0]) `CHK("prog", s != 3'h0, v[5])
    rd(REG_COUNT, v); `CHK("count", n, v[4:0])
  endtask
  task txc(input logic [44:0] x, input logic [5:0] b, input logic [7:0] r);
    `CHK("tx_code", x, tx_code) `CHK("tx_bits", b, tx_bits) `CHK("tx_reason", r, tx_reason) `CHK("tx_n", 1, txn)
  endtask
  function logic [31:0] cw(logic [1:0] l, r, f, h, logic a);
    return {22'h0, a, h, f, r, l, 1'h0};
  endfunction
  function logic [5:0] lb(logic [1:0] l);
    return l == LEN_32 ? BITS_32 : l == LEN_24 ? 6'h18 : 6'h28;
  endfunction
  // Main sequence: reset, formats, roles, programming sessions.
  initial
  begin
    void'($urandom(85590));
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    #1 `CHK("red", 1'h1, led_red)
    `CHK("beep", 1'h1, beeper)
    @(posedge ref_clk);
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc, v); `CHK("unmapped", 32'h0, v)
    rd(REG_CTRL, v); `CHK("ctrl", CTRL_RESET, v[9:0])
    `CHK("expander", 1'h1, exp_ctrl_en)
    for (int l = 0; l < 3; l++)
      for (int k = 0; k < 5; k++)
      begin
        wr(REG_CTRL, cw(2'(l), k == 4 ? PORT_STD : PORT_WOUT, 2'(k), HID_RAW, 1'h0));
        c = 45'({$urandom, $urandom});
        card(1'h0, 1'h0, 1'h0, c);
        txc(c & ((45'h1 << lb(2'(l))) - 45'h1), k == 4 ? lb(2'(l)) : fb[k % 4], REASON_OWN);
        `CHK("wout", k != 4, wout_en)
      end
    for (int k = 0; k < 2; k++)
    begin
      wr(REG_CTRL, cw(LEN_24, 2'(k), FMT_26, k ? HID_AUTO : HID_RAW, 1'h0));
      c = 45'({$urandom, $urandom}); card_bits <= BITS_26;
      card(1'h1, 1'h0, 1'h0, c);
      txc(k ? c & 45'h3ff_ffff : c, k ? BITS_26 : BITS_45, REASON_OWN);
    end
    wr(REG_CTRL, cw(LEN_40, PORT_WIN, FMT_26, HID_AUTO, 1'h0));
    c = 45'({$urandom, $urandom});
    txn = 0; entry_code <= c; entry_valid <= 1'h1; @(posedge ref_clk);
    entry_valid <= 1'h0; repeat (4) @(posedge ref_clk);
    txc(c, BITS_45, REASON_ENTRY);
    `CHK("pin_oe_n", 1'h0, io_pin_oe_n)
    wr(REG_CTRL, cw(LEN_40, PORT_STD, FMT_26, HID_AUTO, 1'h0));
    card(1'h0, 1'h1, 1'h0, '0); st(RMCE_ENROLL, 5'h0);
    for (int i = 1; i < 5; i++)
    begin
      repeat (30) @(posedge ref_clk);
      card(1'h0, 1'h0, 1'h0, 45'(i));
    end
    st(RMCE_ENROLL, 5'h4);
    repeat (TO + 10) @(posedge ref_clk); st(RMCE_IDLE, 5'h4);
    card(1'h0, 1'h0, 1'h1, '0); card(1'h0, 1'h0, 1'h0, 45'h4); st(RMCE_REVOKE, 5'h3);
    repeat (TO + 10) @(posedge ref_clk);
    repeat (6) card(1'h0, 1'h1, 1'h0, '0); st(RMCE_NBR_WAIT, 5'h3);
    card(1'h0, 1'h0, 1'h0, 45'h2); st(RMCE_NBR_REF, 5'h3);
    card(1'h0, 1'h0, 1'h1, '0); st(RMCE_IDLE, 5'h2);
    repeat (6) card(1'h0, 1'h1, 1'h0, '0);
    card(1'h0, 1'h0, 1'h0, 45'h2); card(1'h0, 1'h1, 1'h0, '0); st(RMCE_IDLE, 5'h1);
    repeat (6) card(1'h0, 1'h0, 1'h1, '0); st(RMCE_IDLE, 5'h0);
    wr(REG_CTRL, cw(LEN_40, PORT_STD, FMT_26, HID_AUTO, 1'h1));
    card(1'h0, 1'h1, 1'h0, '0); st(RMCE_IDLE, 5'h0);
    wr(REG_CTRL, 32'h1); repeat (3) @(posedge ref_clk);
    `CHK("archive", 1, arn)
    wr(REG_CTRL, cw(LEN_40, PORT_WOUT, FMT_26, HID_AUTO, 1'h0));
    beep_req <= 1'h1; lamp_req <= 1'h1; tamper_local <= 1'h1; repeat (10) @(posedge ref_clk);
    `CHK("beeper", 1'h1, beeper)
    `CHK("yellow", 1'h1, led_yellow)
    `CHK("relay", 1'h1, relay_out)
    beep_req <= 1'h0; lamp_req <= 1'h0; repeat (10) @(posedge ref_clk);
    `CHK("yellow_off", 1'h0, led_yellow)
    wrap_up;
  end
  // Cuts a hang short well past the expected run length.
  initial
  begin
    #2ms;
    fails++;
    wrap_up;
  end
endmodule
